// ### rtl/dual_mode_state_sequencer_consts.svh
// constants for the dual mode state sequencer: addresses, bit positions,
// table sizes and power-up contents of the freq mode table
// assumes a byte-wide register port with 10-bit addresses
// Summary of operation
// R1 - both sequencers disabled: blocks follow manual registers 0x045 to 0x048
// R2 - sixteen modes each; sixteen freq chain states, seventy transmit states
// R3 - freq mode: buffer bit, three band pairs, attenuator, corner, low-pass bit
// R4 - ready/active pair: neither set is sleep, both set is active
// R5 - transmit mode: four amplifier pairs plus three splitter enables
// R6 - each state is a four-bit index selecting mode 0 to 15
// R7 - loop holds depth plus one states, depth zero leaves state 1
// R8 - transmit depth in 0x017 bits 6:0, freq chain depth bits 3:0
// R9 - pulse rise preloads state; latch applies settings on pulse fall
// R10 - with bypass high, settings apply right after the rising edge
// R11 - freq follow-sleep bit 6 forces freq chain asleep with transmitter
// R12 - freq hold bit 5 stops freq advancing while forced asleep
// R13 - transmit follow-sleep bit 6 forces transmitter asleep with freq chain
// R14 - transmit hold bit 5 stops transmit advancing while forced asleep
// R15 - control bit 7 enables each sequencer; software sets it first
// R16 - state 0 always applies mode 0; mode 0 contents stay writable
// R17 - reset pulse moves pointer to state 0 from anywhere, anytime
// R18 - advance steps one state; after last state wraps to state 1
// R19 - register 0x044 bit 3 resets, bit 2 advances the freq chain
// R20 - freq modes at 0x070 to 0x08F, freq states at 0x03C to 0x043
// R21 - transmit modes at 0x050 to 0x06F, states at 0x019 to 0x03B
// R22 - freq mode table powers up with nine preset modes
// R23 - register 0x044 bit 1 resets, bit 0 advances the transmitter
// R24 - disabled sequencer ignores pulses and keeps its pointer
`ifndef DUAL_MODE_STATE_SEQUENCER_CONSTS_SVH
`define DUAL_MODE_STATE_SEQUENCER_CONSTS_SVH

// ****************************************************************
// register addresses
// ****************************************************************
`define ADDR_TX_CTRL 10'h016
`define ADDR_TX_DEPTH 10'h017
`define ADDR_FREQ_CFG 10'h018
`define ADDR_TX_STATE_BASE 10'h019
`define ADDR_TX_STATE_LAST 10'h03B
`define ADDR_FREQ_STATE_BASE 10'h03C
`define ADDR_FREQ_STATE_LAST 10'h043
`define ADDR_SOFT_STROBE 10'h044
`define ADDR_MANUAL_BASE 10'h045
`define ADDR_MANUAL_LAST 10'h048
`define ADDR_TX_MODE_BASE 10'h050
`define ADDR_TX_MODE_LAST 10'h06F
`define ADDR_FREQ_MODE_BASE 10'h070
`define ADDR_FREQ_MODE_LAST 10'h08F

// ****************************************************************
// bit positions
// ****************************************************************
`define BIT_SEQ_ENABLE 7
`define BIT_FOLLOW_SLEEP 6
`define BIT_SLEEP_HOLD 5
`define BIT_LATCH_BYPASS 4
`define BIT_SOFT_FREQ_RESET 3
`define BIT_SOFT_FREQ_ADVANCE 2
`define BIT_SOFT_TX_RESET 1
`define BIT_SOFT_TX_ADVANCE 0

// ****************************************************************
// table sizes and reset values
// ****************************************************************
`define MODE_COUNT 16
`define FREQ_STATE_COUNT 16
`define TX_STATE_COUNT 70
`define CTRL_RESET 8'h00
// nine freq presets, two bytes per mode, mode 0 in the low bytes
`define FREQ_MODE_PRESETS 144'h1F6B_9F6B_1F6E_9F6E_537A_477A_D37A_1F6A_0000

`endif

// ### rtl/seq_pkg.sv
// types shared by the dual mode state sequencer
// assumes the constants header sits beside it under rtl/
`include "dual_mode_state_sequencer_consts.svh"
package seq_pkg;

  // power state of one band or amplifier
  typedef enum logic [1:0] {
    PWR_SLEEP = 2'b00,
    PWR_READY = 2'b01,
    PWR_ACTIVE = 2'b11
  } pwr_t;

  // freq chain mode as stored: {odd byte, even byte}
  typedef struct packed {
    logic bandpass_corner;
    logic lpf;
    logic spare1;
    logic [4:0] attn;
    logic spare0;
    logic inBuf;
    logic [1:0] bandLow;
    logic [1:0] bandMid;
    logic [1:0] bandHigh;
  } freq_mode_t;

  // transmit mode as stored: {odd byte, even byte}
  typedef struct packed {
    logic [4:0] spare;
    logic split34;
    logic split12;
    logic splitFirst;
    logic [1:0] pa4;
    logic [1:0] pa3;
    logic [1:0] pa2;
    logic [1:0] pa1;
  } tx_mode_t;

  // decoded freq chain configuration driven to the analog side
  typedef struct packed {
    logic inBuf;
    pwr_t bandLow;
    pwr_t bandMid;
    pwr_t bandHigh;
    logic [4:0] attn;
    logic bandpassCorner;
    logic lpf;
  } freq_cfg_t;

  // decoded transmitter configuration driven to the analog side
  typedef struct packed {
    pwr_t pa1;
    pwr_t pa2;
    pwr_t pa3;
    pwr_t pa4;
    logic splitFirst;
    logic split12;
    logic split34;
  } tx_cfg_t;

  // register file and output state of the top module
  typedef struct packed {
    logic [7:0] txCtrl;
    logic [7:0] txDepth;
    logic [7:0] freqCfg;
    logic [34:0][7:0] txStates;
    logic [7:0][7:0] freqStates;
    logic [3:0][7:0] manual;
    logic [31:0][7:0] txModes;
    logic [31:0][7:0] freqModes;
    logic [3:0] softStrobe;
    logic [7:0] rdData;
    freq_cfg_t freqOut;
    tx_cfg_t txOut;
  } top_state_t;

endpackage

// ### rtl/dual_mode_state_sequencer.sv
// two mode/state sequencers for the freq chain and the transmitter,
// with their register file and manual override path
// assumes pins and register port are synchronous to clk, and that the
// serial port logic presents one byte write or read per request
`timescale 1ns/10ps
`include "dual_mode_state_sequencer_consts.svh"

// ****************************************************************
// pointer of one sequencer: preload on rise, apply on fall
// ****************************************************************
module seq_pointer #(
  parameter int NUM_STATES = 16,
  parameter int PTR_W = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic bypass,
  input wire logic hold,
  input wire logic resetPulse,
  input wire logic advancePulse,
  input wire logic [PTR_W-1:0] depth,
  output logic [PTR_W-1:0] pointer,
  output logic [PTR_W-1:0] applied
);
  typedef struct packed {
    logic [PTR_W-1:0] ptr;
    logic [PTR_W-1:0] held;
    logic rstPrev;
    logic advPrev;
  } ptr_state_t;

  localparam logic [PTR_W-1:0] LAST_STATE = PTR_W'(NUM_STATES - 1);
  localparam logic [PTR_W-1:0] ONE = PTR_W'(1);

  ptr_state_t s_r;
  ptr_state_t s_nxt;
  logic rstRise;
  logic advRise;
  logic anyFall;

  // edge detection on the combined pin and soft pulses
  assign rstRise = resetPulse & ~s_r.rstPrev;
  assign advRise = advancePulse & ~s_r.advPrev;
  assign anyFall = (~resetPulse & s_r.rstPrev) |
                   (~advancePulse & s_r.advPrev);

  // pointer movement and settings latch
  always_comb begin
    s_nxt = s_r;
    s_nxt.rstPrev = resetPulse;
    s_nxt.advPrev = advancePulse;
    if (enable) begin // R15 R24
      if (rstRise) begin
        s_nxt.ptr = '0; // R17
      end else if (advRise && !hold) begin // R12 R14
        // wrap past the loop end, or past the last entry if depth
        // reaches beyond the table
        if (s_r.ptr > depth || s_r.ptr == LAST_STATE) begin // R7
          s_nxt.ptr = ONE; // R18
        end else begin
          s_nxt.ptr = s_r.ptr + ONE; // R18
        end
      end
      if (bypass) begin
        s_nxt.held = s_nxt.ptr; // R10
      end else if (anyFall) begin
        s_nxt.held = s_r.ptr; // R9
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pointer = s_r.ptr;
  assign applied = s_r.held;
endmodule

// ****************************************************************
// top: register file, mode lookup, sleep coupling, manual path
// ****************************************************************
module dual_mode_state_sequencer #(
  parameter int ADDR_W = 10
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic freqChainResetPin,
  input wire logic freqChainAdvancePin,
  input wire logic transmitResetPin,
  input wire logic transmitAdvancePin,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  output logic [7:0] regRdData,
  output seq_pkg::freq_cfg_t freqChainCfg,
  output seq_pkg::tx_cfg_t transmitCfg,
  output logic [3:0] freqChainPointer,
  output logic [6:0] transmitPointer
);

  // decode a stored ready/active pair into a power state
  function automatic seq_pkg::pwr_t decodePair(input logic [1:0] pair);
    seq_pkg::pwr_t p;
    case (pair)
      2'b00: p = seq_pkg::PWR_SLEEP; // R4
      2'b11: p = seq_pkg::PWR_ACTIVE; // R4
      default: p = seq_pkg::PWR_READY;
    endcase
    return p;
  endfunction

  seq_pkg::top_state_t s_r;
  seq_pkg::top_state_t s_nxt;

  logic freqEnable;
  logic txEnable;
  logic freqBypass;
  logic txBypass;
  logic freqHold;
  logic txHold;
  logic freqResetPulse;
  logic freqAdvancePulse;
  logic txResetPulse;
  logic txAdvancePulse;
  logic [3:0] freqPtr;
  logic [6:0] txPtr;
  logic [3:0] freqApplied;
  logic [6:0] txApplied;
  logic [3:0] freqModeIdx;
  logic [3:0] txModeIdx;
  seq_pkg::freq_mode_t freqMode;
  seq_pkg::tx_mode_t txMode;
  logic freqRawSleep;
  logic txRawSleep;
  logic freqForced;
  logic txForced;
  logic [ADDR_W-1:0] offs;

  // control bits
  assign freqEnable = s_r.freqCfg[`BIT_SEQ_ENABLE]; // R15
  assign txEnable = s_r.txCtrl[`BIT_SEQ_ENABLE]; // R15
  assign freqBypass = s_r.freqCfg[`BIT_LATCH_BYPASS];
  assign txBypass = s_r.txCtrl[`BIT_LATCH_BYPASS];

  // pins or soft strobes drive each sequencer
  assign freqResetPulse = freqChainResetPin |
                          s_r.softStrobe[`BIT_SOFT_FREQ_RESET]; // R19
  assign freqAdvancePulse = freqChainAdvancePin |
                            s_r.softStrobe[`BIT_SOFT_FREQ_ADVANCE]; // R19
  assign txResetPulse = transmitResetPin |
                        s_r.softStrobe[`BIT_SOFT_TX_RESET]; // R23
  assign txAdvancePulse = transmitAdvancePin |
                          s_r.softStrobe[`BIT_SOFT_TX_ADVANCE]; // R23

  // hold advancing while forced asleep by the other block
  assign freqHold = s_r.freqCfg[`BIT_SLEEP_HOLD] & freqForced; // R12
  assign txHold = s_r.txCtrl[`BIT_SLEEP_HOLD] & txForced; // R14

  seq_pointer #(
    .NUM_STATES(`FREQ_STATE_COUNT), // R2
    .PTR_W(4)
  ) freqSeq (
    .clk(clk),
    .resetn(resetn),
    .enable(freqEnable),
    .bypass(freqBypass),
    .hold(freqHold),
    .resetPulse(freqResetPulse),
    .advancePulse(freqAdvancePulse),
    .depth(s_r.freqCfg[3:0]), // R8
    .pointer(freqPtr),
    .applied(freqApplied)
  );

  seq_pointer #(
    .NUM_STATES(`TX_STATE_COUNT), // R2
    .PTR_W(7)
  ) txSeq (
    .clk(clk),
    .resetn(resetn),
    .enable(txEnable),
    .bypass(txBypass),
    .hold(txHold),
    .resetPulse(txResetPulse),
    .advancePulse(txAdvancePulse),
    .depth(s_r.txDepth[6:0]), // R8
    .pointer(txPtr),
    .applied(txApplied)
  );

  // state to mode index: odd states in the high nibble, state 0 fixed
  always_comb begin
    freqModeIdx = s_r.freqStates[freqApplied[3:1]][3:0]; // R6
    if (freqApplied[0]) begin
      freqModeIdx = s_r.freqStates[freqApplied[3:1]][7:4]; // R6
    end
    if (freqApplied == 4'h0) begin
      freqModeIdx = 4'h0; // R16
    end
    txModeIdx = s_r.txStates[txApplied[6:1]][3:0]; // R6
    if (txApplied[0]) begin
      txModeIdx = s_r.txStates[txApplied[6:1]][7:4]; // R6
    end
    if (txApplied == 7'h00) begin
      txModeIdx = 4'h0; // R16
    end
  end

  // mode source: sequencer table, or manual registers when both sequencers are disabled
  always_comb begin
    freqMode = seq_pkg::freq_mode_t'({s_r.freqModes[{freqModeIdx, 1'b1}],
                                      s_r.freqModes[{freqModeIdx, 1'b0}]});
    txMode = seq_pkg::tx_mode_t'({s_r.txModes[{txModeIdx, 1'b1}],
                                  s_r.txModes[{txModeIdx, 1'b0}]});
    if (!freqEnable && !txEnable) begin // R1
      freqMode = seq_pkg::freq_mode_t'({s_r.manual[3], s_r.manual[2]});
      txMode = seq_pkg::tx_mode_t'({s_r.manual[1], s_r.manual[0]});
    end
  end

  // sleep coupling between the two blocks
  assign freqRawSleep = ~|{freqMode.bandLow, freqMode.bandMid,
                           freqMode.bandHigh};
  assign txRawSleep = ~|{txMode.pa1, txMode.pa2, txMode.pa3, txMode.pa4};
  assign freqForced = s_r.freqCfg[`BIT_FOLLOW_SLEEP] & txRawSleep; // R11
  assign txForced = s_r.txCtrl[`BIT_FOLLOW_SLEEP] & freqRawSleep; // R13

  assign offs = regAddr;

  // register writes, soft strobes, read data and output registers
  always_comb begin
    s_nxt = s_r;
    s_nxt.softStrobe = 4'h0;
    if (regWrEn) begin
      if (regAddr == `ADDR_TX_CTRL) begin
        s_nxt.txCtrl = regWrData;
      end else if (regAddr == `ADDR_TX_DEPTH) begin
        s_nxt.txDepth = regWrData;
      end else if (regAddr == `ADDR_FREQ_CFG) begin
        s_nxt.freqCfg = regWrData;
      end else if (regAddr >= `ADDR_TX_STATE_BASE &&
                   regAddr <= `ADDR_TX_STATE_LAST) begin // R21
        s_nxt.txStates[6'(offs - `ADDR_TX_STATE_BASE)] = regWrData;
      end else if (regAddr >= `ADDR_FREQ_STATE_BASE &&
                   regAddr <= `ADDR_FREQ_STATE_LAST) begin // R20
        s_nxt.freqStates[3'(offs - `ADDR_FREQ_STATE_BASE)] = regWrData;
      end else if (regAddr == `ADDR_SOFT_STROBE) begin
        s_nxt.softStrobe = regWrData[3:0]; // R19 R23
      end else if (regAddr >= `ADDR_MANUAL_BASE &&
                   regAddr <= `ADDR_MANUAL_LAST) begin // R1
        s_nxt.manual[2'(offs - `ADDR_MANUAL_BASE)] = regWrData;
      end else if (regAddr >= `ADDR_TX_MODE_BASE &&
                   regAddr <= `ADDR_TX_MODE_LAST) begin // R21
        s_nxt.txModes[5'(offs - `ADDR_TX_MODE_BASE)] = regWrData;
      end else if (regAddr >= `ADDR_FREQ_MODE_BASE &&
                   regAddr <= `ADDR_FREQ_MODE_LAST) begin // R20
        s_nxt.freqModes[5'(offs - `ADDR_FREQ_MODE_BASE)] = regWrData;
      end
    end

    // read data, one cycle after the address; unmapped reads as zero
    s_nxt.rdData = 8'h00;
    if (regAddr == `ADDR_TX_CTRL) begin
      s_nxt.rdData = s_r.txCtrl;
    end else if (regAddr == `ADDR_TX_DEPTH) begin
      s_nxt.rdData = s_r.txDepth;
    end else if (regAddr == `ADDR_FREQ_CFG) begin
      s_nxt.rdData = s_r.freqCfg;
    end else if (regAddr >= `ADDR_TX_STATE_BASE &&
                 regAddr <= `ADDR_TX_STATE_LAST) begin
      s_nxt.rdData = s_r.txStates[6'(offs - `ADDR_TX_STATE_BASE)];
    end else if (regAddr >= `ADDR_FREQ_STATE_BASE &&
                 regAddr <= `ADDR_FREQ_STATE_LAST) begin
      s_nxt.rdData = s_r.freqStates[3'(offs - `ADDR_FREQ_STATE_BASE)];
    end else if (regAddr >= `ADDR_MANUAL_BASE &&
                 regAddr <= `ADDR_MANUAL_LAST) begin
      s_nxt.rdData = s_r.manual[2'(offs - `ADDR_MANUAL_BASE)];
    end else if (regAddr >= `ADDR_TX_MODE_BASE &&
                 regAddr <= `ADDR_TX_MODE_LAST) begin
      s_nxt.rdData = s_r.txModes[5'(offs - `ADDR_TX_MODE_BASE)];
    end else if (regAddr >= `ADDR_FREQ_MODE_BASE &&
                 regAddr <= `ADDR_FREQ_MODE_LAST) begin
      s_nxt.rdData = s_r.freqModes[5'(offs - `ADDR_FREQ_MODE_BASE)];
    end

    // freq chain outputs, all zero while forced asleep
    s_nxt.freqOut.inBuf = freqMode.inBuf; // R3
    s_nxt.freqOut.bandLow = decodePair(freqMode.bandLow); // R3 R4
    s_nxt.freqOut.bandMid = decodePair(freqMode.bandMid);
    s_nxt.freqOut.bandHigh = decodePair(freqMode.bandHigh);
    s_nxt.freqOut.attn = freqMode.attn;
    s_nxt.freqOut.bandpassCorner = freqMode.bandpass_corner;
    s_nxt.freqOut.lpf = freqMode.lpf;
    if (freqForced) begin
      s_nxt.freqOut = '0; // R11
    end

    // transmitter outputs, all zero while forced asleep
    s_nxt.txOut.pa1 = decodePair(txMode.pa1); // R5 R4
    s_nxt.txOut.pa2 = decodePair(txMode.pa2);
    s_nxt.txOut.pa3 = decodePair(txMode.pa3);
    s_nxt.txOut.pa4 = decodePair(txMode.pa4);
    s_nxt.txOut.splitFirst = txMode.splitFirst; // R5
    s_nxt.txOut.split12 = txMode.split12;
    s_nxt.txOut.split34 = txMode.split34;
    if (txForced) begin
      s_nxt.txOut = '0; // R13
    end
  end

  // state register; freq mode table comes up with its presets
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_r <= '0;
      s_r.txCtrl <= `CTRL_RESET;
      s_r.freqCfg <= `CTRL_RESET;
      s_r.freqModes <= {112'h0, `FREQ_MODE_PRESETS}; // R22
    end else begin
      s_r <= s_nxt;
    end
  end

  assign regRdData = s_r.rdData;
  assign freqChainCfg = s_r.freqOut;
  assign transmitCfg = s_r.txOut;
  assign freqChainPointer = freqPtr;
  assign transmitPointer = txPtr;
endmodule

// ### tb/dual_mode_state_sequencer_props.sv
// concurrent checks on the ports of the dual mode state sequencer
// assumes seq_pkg is compiled first; bound into every instance of the top
`timescale 1ns/10ps
module dual_mode_state_sequencer_props #(
  parameter int ADDR_W = 10
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic freqChainResetPin,
  input wire logic freqChainAdvancePin,
  input wire logic transmitResetPin,
  input wire logic transmitAdvancePin,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic [7:0] regRdData,
  input wire seq_pkg::freq_cfg_t freqChainCfg,
  input wire seq_pkg::tx_cfg_t transmitCfg,
  input wire logic [3:0] freqChainPointer,
  input wire logic [6:0] transmitPointer
);
  // ****************************************************************
  // shadow of the control bytes
  // ****************************************************************
  logic [7:0] txCtl_r;
  logic [7:0] txDep_r;
  logic [7:0] fCtl_r;
  logic fSleep;
  logic tSleep;
  // capture each control byte as it is written
  always_ff @(posedge clk) begin
    if (!resetn) begin
      txCtl_r <= 8'h00;
      txDep_r <= 8'h00;
      fCtl_r <= 8'h00;
    end else if (regWrEn) begin
      if (regAddr == 10'h016) txCtl_r <= regWrData;
      if (regAddr == 10'h017) txDep_r <= regWrData;
      if (regAddr == 10'h018) fCtl_r <= regWrData;
    end
  end
  // a block sleeps when all its pairs are off
  assign fSleep = {freqChainCfg.bandLow, freqChainCfg.bandMid,
    freqChainCfg.bandHigh} == 6'h00;
  assign tSleep = {transmitCfg.pa1, transmitCfg.pa2, transmitCfg.pa3,
    transmitCfg.pa4} == 8'h00;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  read_gap_a: assert property (regAddr inside {10'h044,
    [10'h049:10'h04F]} |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  ctl_readback_a: assert property (
    regWrEn && regAddr inside {[10'h016:10'h018]} ##1
    !regWrEn && $stable(regAddr) |=> regRdData == $past(regWrData, 2))
    else $error("control byte readback wrong");
  off_pointer_a: assert property (!fCtl_r[7] ##1 !fCtl_r[7]
    |=> $stable(freqChainPointer))
    else $error("disabled pointer moved");
  f_reset_a: assert property ($rose(freqChainResetPin) && fCtl_r[7]
    |=> freqChainPointer == 4'h0)
    else $error("freq reset pin missed state 0");
  t_reset_a: assert property ($rose(transmitResetPin) && txCtl_r[7]
    |=> transmitPointer == 7'h00)
    else $error("tx reset pin missed state 0");
  f_wrap_a: assert property ($rose(freqChainAdvancePin) &&
    !freqChainResetPin && fCtl_r[7] && !fCtl_r[5] && fCtl_r[3:0] != 4'hF
    && freqChainPointer == fCtl_r[3:0] + 4'h1 |=> freqChainPointer == 4'h1)
    else $error("freq loop did not wrap to state 1");
  t_step_a: assert property ($rose(transmitAdvancePin) &&
    !transmitResetPin && txCtl_r[7] && !txCtl_r[5] &&
    transmitPointer <= txDep_r[6:0] && transmitPointer < 7'h45
    |=> transmitPointer == $past(transmitPointer) + 7'h01)
    else $error("tx advance not one step");
  latch_hold_a: assert property (fCtl_r[7] && !fCtl_r[4] &&
    !fCtl_r[6] && freqChainAdvancePin && $past(freqChainAdvancePin)
    |=> $stable(freqChainCfg))
    else $error("latched config changed before fall");
  t_follow_a: assert property ((fSleep && txCtl_r[6] &&
    !fCtl_r[6]) [*4] |-> transmitCfg == '0)
    else $error("tx not forced asleep");
  f_follow_a: assert property ((tSleep && fCtl_r[6] &&
    !txCtl_r[6]) [*4] |-> freqChainCfg == '0)
    else $error("freq chain not forced asleep");
  t_hold_a: assert property ($rose(transmitAdvancePin) &&
    txCtl_r[7] && txCtl_r[5] && txCtl_r[6] && !fCtl_r[6] && fSleep
    |=> $stable(transmitPointer))
    else $error("tx advanced while held asleep");

  // main scenarios reached
  wrap_seen_c: cover property (freqChainPointer == 4'h3 ##1
    freqChainPointer == 4'h1);
  forced_seen_c: cover property (txCtl_r[6] && fSleep ##1 tSleep);
  manual_seen_c: cover property (!fCtl_r[7] && !txCtl_r[7] && !tSleep);
endmodule

bind dual_mode_state_sequencer dual_mode_state_sequencer_props #(
  .ADDR_W(ADDR_W)
) props_inst (
  .clk(clk),
  .resetn(resetn),
  .freqChainResetPin(freqChainResetPin),
  .freqChainAdvancePin(freqChainAdvancePin),
  .transmitResetPin(transmitResetPin),
  .transmitAdvancePin(transmitAdvancePin),
  .regAddr(regAddr),
  .regWrData(regWrData),
  .regWrEn(regWrEn),
  .regRdData(regRdData),
  .freqChainCfg(freqChainCfg),
  .transmitCfg(transmitCfg),
  .freqChainPointer(freqChainPointer),
  .transmitPointer(transmitPointer)
);

// ### tb/array_ctrl_model.sv
// array controller model driving the four sequencer pulse lines
// assumes the bench calls its tasks; lines move 1ns after clk rises
`timescale 1ns/10ps
module array_ctrl_model (
  input wire logic clk,
  output logic [3:0] pins
);
  // ****************************************************************
  // lines: 0 freq reset, 1 freq advance, 2 tx reset, 3 tx advance
  // ****************************************************************
  initial pins = 4'h0;
  // raise one line just after an edge
  task automatic raise(input int i);
    @(posedge clk);
    #1 pins[i] = 1'b1;
  endtask
  // drop one line; the next raise waits an edge, so low is seen
  task automatic drop(input int i);
    @(posedge clk);
    #1 pins[i] = 1'b0;
  endtask
  // whole pulse, high for hi edges: 1 is prompt, more is slow
  task automatic pulse(input int i, input int hi);
    raise(i);
    repeat (hi - 1) @(posedge clk);
    drop(i);
  endtask
endmodule

// ### tb/dual_mode_state_sequencer_bench.sv
// self-checking bench for the dual mode state sequencer
// assumes rtl package, header and the array controller model beside it
`timescale 1ns/10ps
module dual_mode_state_sequencer_bench;
  // ****************************************************************
  // clock, reset, wiring
  // ****************************************************************
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [9:0] regAddr = 10'h000;
  logic [7:0] regWrData = 8'h00;
  logic regWrEn = 1'b0;
  logic [7:0] regRdData;
  logic [3:0] pins;
  logic [3:0] fPtr;
  logic [6:0] tPtr;
  seq_pkg::freq_cfg_t fCfg;
  seq_pkg::tx_cfg_t tCfg;
  int errTotal = 0;
  int nTests = 0;
  int cycles = 0;
  // power-up freq modes, even and odd bytes
  localparam logic [7:0] PE [9] = '{8'h00, 8'h6A, 8'h7A, 8'h7A, 8'h7A,
    8'h6E, 8'h6E, 8'h6B, 8'h6B};
  localparam logic [7:0] PO [9] = '{8'h00, 8'h1F, 8'hD3, 8'h47, 8'h53,
    8'h9F, 8'h1F, 8'h9F, 8'h1F};

  always #12.5 clk = ~clk;

  array_ctrl_model ctl (
    .clk(clk),
    .pins(pins)
  );
  dual_mode_state_sequencer dual_mode_state_sequencer_inst (
    .clk(clk),
    .resetn(resetn),
    .freqChainResetPin(pins[0]),
    .freqChainAdvancePin(pins[1]),
    .transmitResetPin(pins[2]),
    .transmitAdvancePin(pins[3]),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrEn(regWrEn),
    .regRdData(regRdData),
    .freqChainCfg(fCfg),
    .transmitCfg(tCfg),
    .freqChainPointer(fPtr),
    .transmitPointer(tPtr)
  );

  // ****************************************************************
  // expected decode, checks and register access
  // ****************************************************************
  function automatic seq_pkg::pwr_t pw(input logic [1:0] p);
    return p == 2'b00 ? seq_pkg::PWR_SLEEP :
      p == 2'b11 ? seq_pkg::PWR_ACTIVE : seq_pkg::PWR_READY;
  endfunction
  function automatic seq_pkg::freq_cfg_t fc(input logic [7:0] e, o);
    return '{e[6], pw(e[5:4]), pw(e[3:2]), pw(e[1:0]), o[4:0], o[7], o[6]};
  endfunction
  function automatic seq_pkg::tx_cfg_t tc(input logic [7:0] e, o);
    return '{pw(e[1:0]), pw(e[3:2]), pw(e[5:4]), pw(e[7:6]),
      o[0], o[1], o[2]};
  endfunction
  task automatic ck(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cc(input logic [15:0] got, input logic [15:0] exp);
    nTests++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED %0t config %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge clk);
    #1 regWrEn = 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1 regAddr = a;
    cyc(2);
    ck(regRdData, exp);
  endtask
  // soft strobe byte, then let the pulse land
  task automatic sw(input logic [7:0] b);
    wr(10'h044, b);
    cyc(4);
  endtask
  task automatic completeRun();
    if (errTotal == 0 && nTests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // cut a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errTotal = errTotal + 1;
      completeRun();
    end
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    int p;
    repeat (4) @(posedge clk);
    #1 resetn = 1'b1;
    // reset contents and refused places
    rd(10'h016, 8'h00);
    rd(10'h018, 8'h00);
    for (int m = 0; m < 9; m++) begin
      rd(10'(10'h070 + 2 * m), PE[m]);
      rd(10'(10'h071 + 2 * m), PO[m]);
    end
    rd(10'h049, 8'h00);
    // manual path with both sequencers off
    wr(10'h045, 8'hC9);
    wr(10'h046, 8'h05);
    wr(10'h047, 8'h5B);
    wr(10'h048, 8'h93);
    cyc(3);
    cc(16'(tCfg), 16'(tc(8'hC9, 8'h05)));
    cc(16'(fCfg), 16'(fc(8'h5B, 8'h93)));
    // pulses ignored while disabled
    ctl.pulse(1, 1);
    cyc(4);
    ck(8'(fPtr), 8'h00);
    // freq loop: states 1..3 use modes 3..5, state 0 nibble ignored
    wr(10'h03C, 8'h32);
    wr(10'h03D, 8'h54);
    wr(10'h018, 8'h82);
    ctl.raise(1);
    cyc(3);
    ck(8'(fPtr), 8'h01);
    cc(16'(fCfg), 16'h0000);
    ctl.drop(1);
    cyc(3);
    cc(16'(fCfg), 16'(fc(PE[3], PO[3])));
    for (int i = 0; i < 3; i++) begin
      p = (i + 1) % 3 + 1;
      ctl.pulse(1, 1);
      cyc(4);
      ck(8'(fPtr), 8'(p));
      cc(16'(fCfg), 16'(fc(PE[p + 2], PO[p + 2])));
    end
    // reset pin mid loop
    ctl.pulse(0, 1);
    cyc(4);
    ck(8'(fPtr), 8'h00);
    cc(16'(fCfg), 16'h0000);
    // bypass: settings follow the rise while the line is high
    wr(10'h018, 8'h92);
    ctl.raise(1);
    cyc(3);
    cc(16'(fCfg), 16'(fc(PE[3], PO[3])));
    ctl.drop(1);
    // soft reset and advance of the freq chain
    sw(8'h08);
    ck(8'(fPtr), 8'h00);
    sw(8'h04);
    ck(8'(fPtr), 8'h01);
    rd(10'h044, 8'h00);
    // transmitter: states 1 and 2 use mode 1, depth 1
    wr(10'h052, 8'h03);
    wr(10'h053, 8'h01);
    wr(10'h019, 8'h10);
    wr(10'h01A, 8'h01);
    wr(10'h017, 8'h01);
    wr(10'h016, 8'h90);
    rd(10'h017, 8'h01);
    ctl.pulse(3, 1);
    cyc(4);
    ck(8'(tPtr), 8'h01);
    cc(16'(tCfg), 16'(tc(8'h03, 8'h01)));
    sw(8'h01);
    ck(8'(tPtr), 8'h02);
    sw(8'h01);
    ck(8'(tPtr), 8'h01);
    ctl.pulse(2, 1);
    cyc(4);
    ck(8'(tPtr), 8'h00);
    ctl.pulse(3, 1);
    // transmitter follows and holds on the sleeping freq chain
    sw(8'h08);
    wr(10'h016, 8'hF0);
    cyc(5);
    cc(16'(tCfg), 16'h0000);
    ctl.pulse(3, 1);
    cyc(4);
    ck(8'(tPtr), 8'h01);
    // freq chain follows and holds on the sleeping transmitter
    wr(10'h016, 8'h90);
    sw(8'h02);
    sw(8'h04);
    wr(10'h018, 8'hF2);
    cyc(5);
    cc(16'(fCfg), 16'h0000);
    sw(8'h04);
    ck(8'(fPtr), 8'h01);
    completeRun();
  end
endmodule
